/* File: bench/dslc_siblings.sv */
`default_nettype none
module dslc_siblings (
  input  wire logic [7:0] permOut,
  input  wire logic       expandOutX,
  input  wire logic       expandOutY,
  output wire logic [7:0] permIn,
  output wire logic       expandX,
  output wire logic       expandY
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // three siblings folded into one stand-in
  // ----------------------------------------
  // not a true permutation; only keeps the loop live
  // pure wiring, so the round sees it in the same cycle
  assign permIn  = {permOut[2:0], permOut[7:3]} ^ 8'h3C;
  assign expandX = expandOutY;
  assign expandY = expandOutX;
endmodule // dslc_siblings
`default_nettype wire

/* File: bench/dslc_slice_assertions.sv */
`default_nettype none
module dslc_slice_checker (
  input wire logic       clock,
  input wire logic       reset_n,
  input wire logic [2:0] functionSelect,
  input wire logic [1:0] dataIn,
  input wire logic       chainEnable,
  input wire logic [1:0] dataOut,
  input wire logic [7:0] permOut,
  input wire logic       expandOutX,
  input wire logic       expandOutY,
  input wire logic       opDone
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // decoded codes
  // ----------------------------------------
  wire logic ld = functionSelect[1:0] == 2'h2;
  wire logic ky = functionSelect[1:0] == 2'h1;
  wire logic ci = functionSelect[1:0] == 2'h0;
  wire logic wt = functionSelect[1:0] == 2'h3;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  a_key_ones: assert property (ky |=> dataOut == 2'h3)
    else $error("key load left data not all ones");
  a_load_shift: assert property (
    ld && !chainEnable ##1 ld[*7] |=> dataOut == $past(dataIn, 8))
    else $error("loaded bit not shifted out after eight edges");
  a_chain_xor: assert property (
    ld && chainEnable ##1 ld[*7] |=> dataOut == $past(dataIn ^ dataOut, 8))
    else $error("chained load did not store the xor");
  a_wait_data: assert property (wt |=> $stable(dataOut))
    else $error("data moved during wait");
  a_wait_expand: assert property (wt |=> $stable({expandOutX, expandOutY}))
    else $error("edge bits moved during wait");
  a_wait_perm: assert property (wt ##1 wt |=> $stable(permOut))
    else $error("round outputs moved during wait");
  a_done_key: assert property (
    $changed(functionSelect) && ky ##1 $stable(functionSelect)[*7] |=> opDone)
    else $error("no done after eight key cycles");
  a_done_data: assert property (
    $changed(functionSelect) && ld ##1 $stable(functionSelect)[*7] |=> opDone)
    else $error("no done after eight data cycles");
  a_done_cipher: assert property (
    $changed(functionSelect) && ci ##1 $stable(functionSelect)[*8]
      ##1 $stable(functionSelect)[*7] |=> opDone)
    else $error("no done after sixteen rounds");
  a_done_pulse: assert property (opDone |=> !opDone)
    else $error("done wider than one cycle");
  c_key: cover property (ky ##1 opDone);
  c_chain: cover property (ld && chainEnable);
  c_cipher: cover property (ci ##1 opDone);
endmodule // dslc_slice_checker

bind dslc_slice dslc_slice_checker chk (.clock, .reset_n, .functionSelect, .dataIn,
  .chainEnable, .dataOut, .permOut, .expandOutX, .expandOutY, .opDone);
`default_nettype wire

/* File: bench/test_des_slice_mode_and_chaining.sv */
`default_nettype none
module test_des_slice_mode_and_chaining;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock = 1'b0;
  logic        reset_n = 1'b0;
  logic [2:0]  functionSelect = 3'h3;
  logic [1:0]  dataIn = 2'h0;
  logic        chainEnable = 1'b0;
  logic [3:0]  keyIn = 4'h0;
  logic [7:0]  permIn, permOut;
  logic [1:0]  dataOut;
  logic        expandX, expandY, expandOutX, expandOutY, opDone, doneSeen;
  logic [15:0] seen;
  int          badCount = 0;
  int          checks = 0;
  int          cycles = 0;

  always #5 clock = ~clock;

  dslc_slice dut (.clock, .reset_n, .functionSelect, .dataIn, .chainEnable, .keyIn,
    .permIn, .expandX, .expandY, .dataOut, .permOut, .expandOutX, .expandOutY, .opDone);
  dslc_siblings sib (.permOut, .expandOutX, .expandOutY, .permIn, .expandX, .expandY);

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks, badCount);
    if (badCount == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      badCount++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one code held n edges, then the wait code set; dataOut logged before each edge
  task automatic run(input logic [2:0] code, input int n, input logic [15:0] din,
                     input logic ch);
    for (int i = 0; i < n; i++) begin
      @(negedge clock);
      seen = {seen[13:0], dataOut};
      functionSelect = code;
      dataIn = din[15 - 2 * (i % 8) -: 2];
      chainEnable = ch;
      keyIn = din[3:0] ^ 4'(i);
    end
    @(negedge clock);
    doneSeen = opDone;
    functionSelect = 3'h3;
    chainEnable = 1'b0;
  endtask

  task automatic t_key;
    run(3'h1, 8, 16'hA5C3, 1'b0);
    check({13'h0, dataOut, doneSeen}, 16'h0007);
    run(3'h5, 8, 16'h3C5A, 1'b0);
    check({13'h0, dataOut, doneSeen}, 16'h0007);
    $display("key test done");
  endtask

  task automatic t_chain;
    run(3'h2, 8, 16'h9E27, 1'b0);
    check({seen[15:1], doneSeen}, 16'hFFFF);
    run(3'h6, 8, 16'h4BD1, 1'b1);
    check(seen, 16'h9E27);
    run(3'h7, 5, 16'hFFFF, 1'b1);
    run(3'h2, 8, 16'h0000, 1'b0);
    check(seen, 16'hD5F6);
    $display("chain test done");
  endtask

  task automatic t_cipher;
    run(3'h4, 16, 16'h0000, 1'b0);
    check({15'h0, doneSeen}, 16'h0001);
    run(3'h0, 16, 16'h0000, 1'b0);
    check({15'h0, doneSeen}, 16'h0001);
    $display("cipher test done");
  endtask

  // reset after a completed data load clears the loaded block
  task automatic t_reset;
    run(3'h2, 8, 16'hC35A, 1'b0);
    reset_n = 1'b0;
    repeat (2) @(negedge clock);
    check({3'h0, dataOut, opDone, permOut, expandOutX, expandOutY}, 16'h0000);
    reset_n = 1'b1;
    run(3'h2, 8, 16'h0000, 1'b0);
    check(seen, 16'h0000);
    $display("mid reset test done");
  endtask

  // far end as receiver: the stored prior block undoes the chaining
  task automatic t_receive;
    logic [15:0] prior;
    logic [15:0] plain;
    prior = 16'h9E27;
    run(3'h2, 8, 16'h3AC5, 1'b0);
    run(3'h0, 16, 16'h0000, 1'b0);
    check({15'h0, doneSeen}, 16'h0001);
    run(3'h2, 8, prior, 1'b1);
    plain = seen;
    run(3'h2, 8, 16'h0000, 1'b0);
    check(seen, plain ^ prior);
    $display("receive test done");
  endtask

  always @(posedge clock) begin
    cycles++;
    if (cycles == 2000) begin
      badCount++;
      conclude();
    end
  end

  initial begin
    repeat (20) @(negedge clock);
    reset_n = 1'b1;
    check({5'h0, dataOut, opDone, permOut}, 16'h0000);
    $display("reset test done");
    t_key();
    t_chain();
    t_reset();
    t_cipher();
    t_receive();
    conclude();
  end
endmodule // test_des_slice_mode_and_chaining
`default_nettype wire

/* File: hw/dslc_slice.sv */
`default_nettype none
module dslc_slice
  import dslc_pkg::*;
#(
  parameter logic [7:0] SLICE_MASK = 8'h5A
) (
  input  wire logic       clock,
  input  wire logic       reset_n,
  input  wire logic [2:0] functionSelect,
  input  wire logic [1:0] dataIn,
  input  wire logic       chainEnable,
  input  wire logic [3:0] keyIn,
  input  wire logic [7:0] permIn,
  input  wire logic       expandX,
  input  wire logic       expandY,
  output logic      [1:0] dataOut,
  output logic      [7:0] permOut,
  output logic            expandOutX,
  output logic            expandOutY,
  output logic            opDone
);

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  dslc_op_e op;

  // top bit matters only for the two cipher codes
  always_comb begin
    case (functionSelect[1:0])
      DSLC_LOW_KEY:  op = DSLC_OP_KEY_LOAD;
      DSLC_LOW_DATA: op = DSLC_OP_DATA_LOAD;
      DSLC_LOW_WAIT: op = DSLC_OP_WAIT;
      DSLC_LOW_CIPHER: begin
        if (functionSelect == DSLC_CODE_ENCIPHER) begin
          op = DSLC_OP_ENCIPHER;
        end else begin
          op = DSLC_OP_DECIPHER;
        end
      end
      default: op = DSLC_OP_WAIT;
    endcase
  end

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [7:0]  leftByte;
  logic [7:0]  rightByte;
  logic [31:0] keyReg;
  logic [4:0]  cycleCount;
  logic [2:0]  lastSelect;
  logic [7:0]  next_leftByte;
  logic [7:0]  next_rightByte;
  logic [31:0] next_keyReg;
  logic [1:0]  loadBits;
  logic [1:0]  chainedBits;
  logic [7:0]  roundF;

  // chaining XOR uses the bits being shifted out this same edge
  assign chainedBits = dataIn ^ dataOut;
  assign loadBits    = chainEnable ? chainedBits : dataIn;
  assign dataOut     = {leftByte[7], rightByte[7]};

  // permutation from the siblings closes the round in this cycle
  assign roundF = permIn;

  // data bytes: swap in cipher rounds, serial shift in data load, all ones in key load
  always_comb begin
    next_leftByte  = leftByte;
    next_rightByte = rightByte;
    case (op)
      DSLC_OP_ENCIPHER: begin
        next_leftByte  = rightByte;
        next_rightByte = leftByte ^ roundF;
      end
      DSLC_OP_DECIPHER: begin
        next_leftByte  = rightByte;
        next_rightByte = leftByte ^ roundF;
      end
      DSLC_OP_KEY_LOAD: begin
        next_leftByte  = DSLC_DATA_ONES;
        next_rightByte = DSLC_DATA_ONES;
      end
      DSLC_OP_DATA_LOAD: begin
        next_leftByte  = {leftByte[6:0], loadBits[1]};
        next_rightByte = {rightByte[6:0], loadBits[0]};
      end
      DSLC_OP_WAIT: begin
        next_leftByte  = leftByte;
        next_rightByte = rightByte;
      end
      default: begin
        next_leftByte  = leftByte;
        next_rightByte = rightByte;
      end
    endcase
  end

  // one key bit enters the low end of each key byte per load edge
  always_comb begin
    next_keyReg = keyReg;
    case (op)
      DSLC_OP_ENCIPHER: next_keyReg = {keyReg[30:0], keyReg[31]};
      DSLC_OP_DECIPHER: next_keyReg = {keyReg[0], keyReg[31:1]};
      DSLC_OP_KEY_LOAD: next_keyReg = {keyReg[30:24], keyIn[3], keyReg[22:16], keyIn[2],
                                       keyReg[14:8], keyIn[1], keyReg[6:0], keyIn[0]};
      DSLC_OP_WAIT:     next_keyReg = keyReg;
      default:          next_keyReg = keyReg;
    endcase
  end

  // ---------------------------------------------------------------
  // round function toward the siblings
  // ---------------------------------------------------------------
  // stand-in substitution; the real tables differ per slice
  function automatic logic [3:0] subst(input logic [5:0] addr);
    logic [3:0] mixed;
    mixed = addr[4:1] ^ {addr[0], addr[5], addr[2], addr[3]};
    subst = {mixed[2:0], mixed[3]} ^ SLICE_MASK[3:0];
  endfunction

  logic [5:0] addrA;
  logic [5:0] addrB;

  // computed from next state so the registered outputs match the round
  assign addrA = {expandX, next_rightByte[7:3]} ^ next_keyReg[5:0];
  assign addrB = {next_rightByte[4:0], expandY} ^ next_keyReg[21:16];

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      permOut <= DSLC_DATA_RESET;
    end else begin
      permOut <= {subst(addrA), subst(addrB)} ^ SLICE_MASK;
    end
  end

  // edge bits for the neighbours come straight from the new right byte
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      expandOutX <= 1'b0;
      expandOutY <= 1'b0;
    end else begin
      expandOutX <= next_rightByte[0];
      expandOutY <= next_rightByte[7];
    end
  end

  // ---------------------------------------------------------------
  // data and key registers
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      leftByte  <= DSLC_DATA_RESET;
      rightByte <= DSLC_DATA_RESET;
    end else begin
      leftByte  <= next_leftByte;
      rightByte <= next_rightByte;
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      keyReg <= DSLC_KEY_RESET;
    end else begin
      keyReg <= next_keyReg;
    end
  end

  // ---------------------------------------------------------------
  // operation length tracking
  // ---------------------------------------------------------------
  // counts restart on any code change; wait never completes
  logic [4:0] opLength;

  always_comb begin
    case (op)
      DSLC_OP_ENCIPHER:  opLength = DSLC_CIPHER_CYCLES;
      DSLC_OP_DECIPHER:  opLength = DSLC_CIPHER_CYCLES;
      DSLC_OP_KEY_LOAD:  opLength = DSLC_LOAD_CYCLES;
      DSLC_OP_DATA_LOAD: opLength = DSLC_LOAD_CYCLES;
      default:           opLength = DSLC_COUNT_RESET;
    endcase
  end

  logic selectChanged;
  logic lastCycle;

  // a fresh code restarts the count even if the operation is the same
  assign selectChanged = functionSelect != lastSelect;
  assign lastCycle     = cycleCount == opLength;

  // reset to the wait code so the first real code counts as a change
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      lastSelect <= {1'b0, DSLC_LOW_WAIT};
    end else begin
      lastSelect <= functionSelect;
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      cycleCount <= DSLC_COUNT_RESET;
    end else if (selectChanged || lastCycle) begin
      cycleCount <= 5'h01;
    end else begin
      cycleCount <= cycleCount + 5'h01;
    end
  end

  // pulse on the edge that completes the last cycle of the operation
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      opDone <= 1'b0;
    end else begin
      opDone <= (opLength != DSLC_COUNT_RESET) &&
                ((selectChanged && opLength == 5'h01) ||
                 (!selectChanged && cycleCount + 5'h01 == opLength));
    end
  end

endmodule // dslc_slice
`default_nettype wire

/* File: shared/dslc_pkg.sv */
// Overview of operation
// - code 000 deciphers, 100 enciphers, 16 cycles
// - low bits 01 key, 10 data, 11 wait
// - chain high in data load: XOR inputs, outputs
// - chaining XOR rides the result shift-out edges
// - transmitter XORs block with prior result, encrypts
// - key and data move on rising edges only
// - key load forces data registers to ones
// - previous result out as next block shifts in
// - key rotates left encipher, right decipher
`default_nettype none
package dslc_pkg;

  // ---------------------------------------------------------------
  // function select codes
  // ---------------------------------------------------------------
  localparam logic [2:0] DSLC_CODE_DECIPHER = 3'h0;
  localparam logic [2:0] DSLC_CODE_ENCIPHER = 3'h4;
  localparam logic [1:0] DSLC_LOW_CIPHER    = 2'h0;
  localparam logic [1:0] DSLC_LOW_KEY       = 2'h1;
  localparam logic [1:0] DSLC_LOW_DATA      = 2'h2;
  localparam logic [1:0] DSLC_LOW_WAIT      = 2'h3;

  // ---------------------------------------------------------------
  // widths, counts and reset values
  // ---------------------------------------------------------------
  localparam int         DSLC_BYTE_W       = 8;
  localparam int         DSLC_KEY_W        = 32;
  localparam logic [4:0] DSLC_CIPHER_CYCLES = 5'h10;
  localparam logic [4:0] DSLC_LOAD_CYCLES   = 5'h08;
  localparam logic [7:0] DSLC_DATA_ONES     = 8'hFF;
  localparam logic [7:0] DSLC_DATA_RESET    = 8'h00;
  localparam logic [31:0] DSLC_KEY_RESET    = 32'h0000_0000;
  localparam logic [4:0] DSLC_COUNT_RESET   = 5'h00;

  typedef enum {
    DSLC_OP_DECIPHER,
    DSLC_OP_ENCIPHER,
    DSLC_OP_KEY_LOAD,
    DSLC_OP_DATA_LOAD,
    DSLC_OP_WAIT
  } dslc_op_e;

endpackage
`default_nettype wire
